/* rtl/pt_pkg.sv */
// constants, register map and state layout of the prescaler and timer block
package pt_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_FLAG_A   = 6'h01;
    localparam logic [5:0] IDX_FLAG_BC  = 6'h02;
    localparam logic [5:0] IDX_PORT_FUNC_SEL_A     = 6'h04;
    localparam logic [5:0] IDX_TMA      = 6'h08;
    localparam logic [5:0] IDX_TMB      = 6'h09;
    localparam logic [5:0] IDX_TCB_LO   = 6'h0A;
    localparam logic [5:0] IDX_TCB_HI   = 6'h0B;
    localparam logic [5:0] IDX_TMC      = 6'h0D;
    localparam logic [5:0] IDX_TCC_LO   = 6'h0E;
    localparam logic [5:0] IDX_TCC_HI   = 6'h0F;
    localparam logic [5:0] IDX_PORT_FUNC_SEL_B     = 6'h10;
    localparam logic [5:0] IDX_CTRL     = 6'h11;

    // field positions
    localparam int FLAG_A_BIT     = 2;
    localparam int FLAG_B_BIT     = 0;
    localparam int FLAG_C_BIT     = 2;
    localparam int PORT_FUNC_SEL_B_PULSE_BIT = 2;
    localparam int WD_ARM_BIT     = 0;
    localparam int MODE_AUTO_BIT  = 3;
    localparam int TMA_BASE_BIT   = 3;

    // mode codes with special meaning
    localparam logic [2:0] TMB_EXT_EVENT = 3'h7;
    localparam logic [2:0] TMA_UNUSED    = 3'h5;

    localparam logic [1:0] AXI_OKAY = 2'h0;

    typedef struct packed {
        logic [10:0] sys_prescaler;
        logic [7:0]  sub_prescaler;
        logic        x1_prev;
        logic        ev_prev;
        logic [3:0]  port_func_sel_a;
        logic [3:0]  timer_a_mode_select;
        logic [3:0]  timer_b_mode_select;
        logic [3:0]  timer_c_mode_select;
        logic [3:0]  port_func_sel_b;
        logic [7:0]  cnt_a;
        logic [7:0]  cnt_b;
        logic [7:0]  cnt_c;
        logic [7:0]  load_b;
        logic [7:0]  load_c;
        logic [3:0]  wr_lo_b;
        logic [3:0]  wr_lo_c;
        logic [3:0]  rd_lo_b;
        logic [3:0]  rd_lo_c;
        logic        flag_a;
        logic        flag_b;
        logic        flag_c;
        logic        wd_arm;
        logic        wd_rst;
        logic        pwm;
        logic        aw_held;
        logic [5:0]  aw_idx;
        logic        w_held;
        logic [3:0]  w_data;
        logic        w_en;
        logic        bvalid;
        logic        rvalid;
        logic [31:0] rdata;
    } pt_state_s;

    localparam pt_state_s STATE_RESET = '0;

endpackage

/* rtl/pt_timers.sv */
// prescalers S and W, timers A, B and C with watchdog and pulse output, AXI4-Lite registers
//
// Functional notes
// - prescaler S clears at reset and, once reset is released, counts every clock outside stop and watch mode.
// - prescaler S counts continuously except during reset, stop or watch mode.
// - prescaler S taps feed timers A, B and C.
// - prescaler W runs from crystal divided by eight; selectable for timer A.
// - timer A resets to zero, counts, wraps after 0xFF with an overflow.
// - timer A overflow sets its request flag at bit 2.
// - time-base select bit set makes timer A count prescaler W output.
// - counter-reset mode code clears prescaler W and timer A.
// - timer B mode picks auto-reload, division, or external event clock.
// - writing timer B load presets the counter, then it counts up.
// - timer B overflows after 0xFF, reloading or restarting from zero.
// - timer B overflow sets its request flag at bit 0.
// - timer C mode picks auto-reload and division; load write presets.
// - timer C overflows after 0xFF, reloading or restarting from zero.
// - timer C overflow sets its request flag at bit 2.
// - with watchdog armed, timer C overflow pulses the watchdog reset output and clears the timer state, keeping bus transactions.
// - watchdog stops with timer C, so it halts in stop and watch mode.
// - timer C drives a pulse output shaped by mode and load, stopping with it.
// - timer A mode is write-only; divisions or subclock modes per bit 3.
// - timer B mode bit 3 auto-reload, codes 0-6 divisions, 7 event.
// - timer C mode bit 3 auto-reload, codes 0-7 divisions.
// - load low then high nibble presets; counter read high first latches low.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module pt_timers (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        stop_mode_i,
    input  wire logic        watch_mode_i,
    input  wire logic        x1_clk_i,
    input  wire logic        ext_event_in_i,
    output logic             pulse_out_pin_o,
    output logic             pulse_out_sel_o,
    output logic             wdt_reset_o,
    output logic [10:0]      sys_prescaler_o,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i
);

    pt_pkg::pt_state_s s_q;
    pt_pkg::pt_state_s s_d;

    // true when the low n bits of a freshly incremented prescaler are all zero
    function automatic logic tap_hit(input logic [10:0] v, input logic [3:0] n);
        logic [10:0] m;
        m = ~(11'h7FF << n);
        return (v & m) == 11'h000;
    endfunction

    // log2 of the division for timers A (bit 3 clear) and C
    function automatic logic [3:0] div_log_ac(input logic [2:0] code);
        case (code)
            3'h0:    return 4'hB;
            3'h1:    return 4'hA;
            3'h2:    return 4'h9;
            3'h3:    return 4'h7;
            3'h4:    return 4'h5;
            3'h5:    return 4'h3;
            3'h6:    return 4'h2;
            default: return 4'h1;
        endcase
    endfunction

    function automatic logic [3:0] div_log_b(input logic [2:0] code);
        case (code)
            3'h0:    return 4'hB;
            3'h1:    return 4'h9;
            3'h2:    return 4'h7;
            3'h3:    return 4'h5;
            3'h4:    return 4'h3;
            3'h5:    return 4'h2;
            default: return 4'h1;
        endcase
    endfunction

    // log2 of the division of crystal edges in time-base mode (includes the fixed divide by 8 for codes 0 to 3; code 4 divides by 4)
    function automatic logic [3:0] div_log_w(input logic [2:0] code);
        case (code)
            3'h0:    return 4'h8;
            3'h1:    return 4'h7;
            3'h2:    return 4'h6;
            3'h3:    return 4'h4;
            default: return 4'h2;
        endcase
    endfunction

    // one counting step: {overflow, next value}
    function automatic logic [8:0] cnt_step(input logic [7:0] c, input logic tick,
                                            input logic reload, input logic [7:0] load);
        if (!tick)
        begin
            return {1'b0, c};
        end
        if (c == 8'hFF)
        begin
            return {1'b1, reload ? load : 8'h00};
        end
        return {1'b0, c + 8'h01};
    endfunction

    assign s_axi_awready_o = !s_q.aw_held && !s_q.bvalid;
    assign s_axi_wready_o  = !s_q.w_held && !s_q.bvalid;
    assign s_axi_arready_o = !s_q.rvalid;
    assign s_axi_bvalid_o  = s_q.bvalid;
    assign s_axi_bresp_o   = pt_pkg::AXI_OKAY;
    assign s_axi_rvalid_o  = s_q.rvalid;
    assign s_axi_rresp_o   = pt_pkg::AXI_OKAY;
    assign s_axi_rdata_o   = s_q.rdata;
    assign wdt_reset_o     = s_q.wd_rst;
    assign sys_prescaler_o = s_q.sys_prescaler;
    assign pulse_out_sel_o = s_q.port_func_sel_b[pt_pkg::PORT_FUNC_SEL_B_PULSE_BIT];
    assign pulse_out_pin_o = s_q.pwm;

    always_comb
    begin
        logic        sys_run;
        logic [10:0] pss_n;
        logic        x1_edge;
        logic [7:0]  psw_n;
        logic        tick_a;
        logic        tick_b;
        logic        tick_c;
        logic        tca_clr;
        logic [8:0]  step_a;
        logic [8:0]  step_b;
        logic [8:0]  step_c;
        logic        aw_hs;
        logic        w_hs;
        logic        do_wr;
        logic [5:0]  wr_idx;
        logic [3:0]  wr_dat;
        logic        wr_en;
        logic [5:0]  rd_idx;
        logic [3:0]  rd_val;
        pt_pkg::pt_state_s keep;

        s_d     = s_q;
        keep    = s_q;
        rd_val  = 4'h0;
        rd_idx  = s_axi_araddr_i[7:2];

        // prescaler S halts in stop and watch modes, which also freezes timer C and timer B outside event mode
        sys_run = !stop_mode_i && !watch_mode_i;
        pss_n   = sys_run ? s_q.sys_prescaler + 11'h001 : s_q.sys_prescaler;
        s_d.sys_prescaler = pss_n;

        // prescaler W counts crystal edges; the low three bits are the fixed divide by 8
        x1_edge     = x1_clk_i && !s_q.x1_prev;
        s_d.x1_prev = x1_clk_i;
        psw_n       = x1_edge ? s_q.sub_prescaler + 8'h01 : s_q.sub_prescaler;
        tca_clr     = s_q.timer_a_mode_select[pt_pkg::TMA_BASE_BIT] && (s_q.timer_a_mode_select[2:1] == 2'b11);
        s_d.sub_prescaler     = tca_clr ? 8'h00 : psw_n;

        if (s_q.timer_a_mode_select[pt_pkg::TMA_BASE_BIT])
        begin
            tick_a = x1_edge && !tca_clr && (s_q.timer_a_mode_select[2:0] != pt_pkg::TMA_UNUSED)
                     && tap_hit({3'h0, psw_n}, div_log_w(s_q.timer_a_mode_select[2:0]));
        end
        else
        begin
            tick_a = sys_run && tap_hit(pss_n, div_log_ac(s_q.timer_a_mode_select[2:0]));
        end

        // external events count on the falling edge of the active-low input
        s_d.ev_prev = ext_event_in_i;
        if (s_q.timer_b_mode_select[2:0] == pt_pkg::TMB_EXT_EVENT)
        begin
            tick_b = s_q.ev_prev && !ext_event_in_i;
        end
        else
        begin
            tick_b = sys_run && tap_hit(pss_n, div_log_b(s_q.timer_b_mode_select[2:0]));
        end
        tick_c = sys_run && tap_hit(pss_n, div_log_ac(s_q.timer_c_mode_select[2:0]));

        step_a = cnt_step(s_q.cnt_a, tick_a, 1'b0, 8'h00);
        step_b = cnt_step(s_q.cnt_b, tick_b, s_q.timer_b_mode_select[pt_pkg::MODE_AUTO_BIT], s_q.load_b);
        step_c = cnt_step(s_q.cnt_c, tick_c, s_q.timer_c_mode_select[pt_pkg::MODE_AUTO_BIT], s_q.load_c);
        s_d.cnt_a = tca_clr ? 8'h00 : step_a[7:0];
        s_d.cnt_b = step_b[7:0];
        s_d.cnt_c = step_c[7:0];

        // pulse output: high from each overflow until the counter meets the inverted load
        if (!sys_run)
        begin
            s_d.pwm = 1'b0;
        end
        else if (step_c[8])
        begin
            s_d.pwm = 1'b1;
        end
        else if (tick_c && (step_c[7:0] == ~s_q.load_c))
        begin
            s_d.pwm = 1'b0;
        end

        // write channel: address and data taken in either order
        aw_hs  = s_axi_awvalid_i && s_axi_awready_o;
        w_hs   = s_axi_wvalid_i && s_axi_wready_o;
        wr_idx = s_q.aw_held ? s_q.aw_idx : s_axi_awaddr_i[7:2];
        wr_dat = s_q.w_held ? s_q.w_data : s_axi_wdata_i[3:0];
        wr_en  = s_q.w_held ? s_q.w_en : s_axi_wstrb_i[0];
        do_wr  = (s_q.aw_held || aw_hs) && (s_q.w_held || w_hs);
        if (s_q.bvalid && s_axi_bready_i)
        begin
            s_d.bvalid = 1'b0;
        end
        if (aw_hs)
        begin
            s_d.aw_held = 1'b1;
            s_d.aw_idx  = s_axi_awaddr_i[7:2];
        end
        if (w_hs)
        begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata_i[3:0];
            s_d.w_en   = s_axi_wstrb_i[0];
        end
        if (do_wr)
        begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
        end
        if (do_wr && wr_en)
        begin
            case (wr_idx)
                pt_pkg::IDX_FLAG_A:
                begin
                    s_d.flag_a = wr_dat[pt_pkg::FLAG_A_BIT];
                end
                pt_pkg::IDX_FLAG_BC:
                begin
                    s_d.flag_b = wr_dat[pt_pkg::FLAG_B_BIT];
                    s_d.flag_c = wr_dat[pt_pkg::FLAG_C_BIT];
                end
                pt_pkg::IDX_PORT_FUNC_SEL_A:   s_d.port_func_sel_a = wr_dat;
                pt_pkg::IDX_TMA:    s_d.timer_a_mode_select = wr_dat;
                pt_pkg::IDX_TMB:    s_d.timer_b_mode_select = wr_dat;
                pt_pkg::IDX_TMC:    s_d.timer_c_mode_select = wr_dat;
                pt_pkg::IDX_PORT_FUNC_SEL_B:   s_d.port_func_sel_b = wr_dat;
                pt_pkg::IDX_CTRL:   s_d.wd_arm = wr_dat[pt_pkg::WD_ARM_BIT];
                pt_pkg::IDX_TCB_LO: s_d.wr_lo_b = wr_dat;
                pt_pkg::IDX_TCC_LO: s_d.wr_lo_c = wr_dat;
                pt_pkg::IDX_TCB_HI:
                begin
                    s_d.load_b = {wr_dat, s_q.wr_lo_b};
                    s_d.cnt_b  = {wr_dat, s_q.wr_lo_b};
                end
                pt_pkg::IDX_TCC_HI:
                begin
                    s_d.load_c = {wr_dat, s_q.wr_lo_c};
                    s_d.cnt_c  = {wr_dat, s_q.wr_lo_c};
                end
                default:
                begin
                    s_d.port_func_sel_a = s_d.port_func_sel_a;
                end
            endcase
        end

        // overflow sets win over a clearing write in the same cycle
        if (step_a[8])
        begin
            s_d.flag_a = 1'b1;
        end
        if (step_b[8])
        begin
            s_d.flag_b = 1'b1;
        end
        if (step_c[8])
        begin
            s_d.flag_c = 1'b1;
        end
        // timer C only overflows while it runs, so the watchdog stops with it
        s_d.wd_rst = step_c[8] && s_q.wd_arm;

        // read channel; mode registers are write-only and read as zero
        if (s_q.rvalid && s_axi_rready_i)
        begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            case (rd_idx)
                pt_pkg::IDX_FLAG_A:  rd_val[pt_pkg::FLAG_A_BIT] = s_q.flag_a;
                pt_pkg::IDX_FLAG_BC:
                begin
                    rd_val[pt_pkg::FLAG_B_BIT] = s_q.flag_b;
                    rd_val[pt_pkg::FLAG_C_BIT] = s_q.flag_c;
                end
                pt_pkg::IDX_PORT_FUNC_SEL_A:    rd_val = s_q.port_func_sel_a;
                pt_pkg::IDX_PORT_FUNC_SEL_B:    rd_val = s_q.port_func_sel_b;
                pt_pkg::IDX_CTRL:    rd_val[pt_pkg::WD_ARM_BIT] = s_q.wd_arm;
                pt_pkg::IDX_TCB_HI:
                begin
                    rd_val      = s_q.cnt_b[7:4];
                    s_d.rd_lo_b = s_q.cnt_b[3:0];
                end
                pt_pkg::IDX_TCC_HI:
                begin
                    rd_val      = s_q.cnt_c[7:4];
                    s_d.rd_lo_c = s_q.cnt_c[3:0];
                end
                pt_pkg::IDX_TCB_LO:  rd_val = s_q.rd_lo_b;
                pt_pkg::IDX_TCC_LO:  rd_val = s_q.rd_lo_c;
                default:             rd_val = 4'h0;
            endcase
            s_d.rvalid = 1'b1;
            s_d.rdata  = {28'h0000000, rd_val};
        end

        // a watchdog reset clears the timer state but keeps bus transactions intact
        if (s_q.wd_rst)
        begin
            keep          = s_d;
            s_d           = pt_pkg::STATE_RESET;
            s_d.x1_prev   = keep.x1_prev;
            s_d.ev_prev   = keep.ev_prev;
            s_d.aw_held   = keep.aw_held;
            s_d.aw_idx    = keep.aw_idx;
            s_d.w_held    = keep.w_held;
            s_d.w_data    = keep.w_data;
            s_d.w_en      = keep.w_en;
            s_d.bvalid    = keep.bvalid;
            s_d.rvalid    = keep.rvalid;
            s_d.rdata     = keep.rdata;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            s_q <= pt_pkg::STATE_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule

/* test/pt_pin_model.sv */
// far-side pin model: crystal clock and active-low external event line
`timescale 1ns/1ps
module pt_pin_model (
    input  wire logic ref_clk_i,
    input  wire logic x1_run_i,
    input  wire logic event_req_i,
    output logic      x1_clk_o,
    output logic      ext_event_in_o
);
    logic [1:0] x1_div_q;
    logic [1:0] ev_cnt_q;

    initial
    begin
        x1_div_q = 2'h0;
        ev_cnt_q = 2'h0;
    end
    // crystal rises every four system clocks and stands low while stopped
    always @(posedge ref_clk_i)
    begin
        x1_div_q <= x1_run_i ? x1_div_q + 2'h1 : 2'h0;
        if (ev_cnt_q != 2'h0)
            ev_cnt_q <= ev_cnt_q - 2'h1;
        else if (event_req_i)
            ev_cnt_q <= 2'h3;
    end
    assign x1_clk_o       = x1_div_q[1];
    // pulled-up line: low for two cycles per event, then back high
    assign ext_event_in_o = ~ev_cnt_q[1];
endmodule

/* test/pt_timers_assertions.sv */
// concurrent checks on the timer block ports
`timescale 1ns/1ps
module pt_timers_assertions (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        stop_mode_i,
    input wire logic        watch_mode_i,
    input wire logic        pulse_out_pin_o,
    input wire logic        pulse_out_sel_o,
    input wire logic        wdt_reset_o,
    input wire logic [10:0] sys_prescaler_o,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_pss_counts: assert property (!stop_mode_i && !watch_mode_i && !wdt_reset_o
        |=> sys_prescaler_o == $past(sys_prescaler_o) + 11'h001) else $error("prescaler did not advance");
    a_pss_halts: assert property ((stop_mode_i || watch_mode_i) && !wdt_reset_o
        |=> $stable(sys_prescaler_o)) else $error("prescaler moved while halted");
    // reset itself is the trigger here, so this one must not be disabled by it
    a_pss_reset: assert property (disable iff (1'h0) rst_i
        |=> sys_prescaler_o == 11'h000 && !wdt_reset_o && !s_axi_rvalid_o) else $error("reset left state");
    a_wdt_clears: assert property (wdt_reset_o
        |=> sys_prescaler_o == 11'h000 && !pulse_out_sel_o && !wdt_reset_o) else $error("watchdog reset weak");
    a_wdt_needs_run: assert property ((stop_mode_i || watch_mode_i) [*3]
        |-> !wdt_reset_o) else $error("watchdog fired while timer halted");
    a_pulse_stops: assert property ((stop_mode_i || watch_mode_i) [*2]
        |-> !pulse_out_pin_o) else $error("pulse output active while halted");
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |=> s_axi_bvalid_o) else $error("write not answered");
    a_busy_refuses: assert property (s_axi_bvalid_o
        |-> !s_axi_awready_o && !s_axi_wready_o) else $error("write taken while response pending");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o && s_axi_rdata_o[31:4] == 28'h0000000) else $error("read answer wrong");
    a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped early");
endmodule

/* test/test_prescalers_and_three_timers.sv */
// self-checking bench for the prescaler and timer block
`timescale 1ns/1ps
module test_prescalers_and_three_timers;
    typedef struct packed {logic [5:0] idx; logic [3:0] wd; logic [3:0] exp;} pt_row_s;
    logic        ref_clk_i, rst_i, stop_mode_i, watch_mode_i, x1_run, ev_req, x1_clk, ev_n, pulse, psel, wdt;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [10:0] sys_prescaler;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp;
    int          failures, samples_checked, cycles, n;
    pt_row_s     rows [6];

    pt_timers DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .stop_mode_i(stop_mode_i), .watch_mode_i(watch_mode_i),
        .x1_clk_i(x1_clk), .ext_event_in_i(ev_n), .pulse_out_pin_o(pulse), .pulse_out_sel_o(psel),
        .wdt_reset_o(wdt), .sys_prescaler_o(sys_prescaler), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    pt_pin_model pins (.ref_clk_i(ref_clk_i), .x1_run_i(x1_run), .event_req_i(ev_req), .x1_clk_o(x1_clk),
        .ext_event_in_o(ev_n));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // bready stays high between writes so that back-to-back calls never drive it twice in one step
    task automatic wr(input logic [5:0] idx, input logic [3:0] d);
        bit b;
        bit ta;
        bit tw;
        bit tb;
        b = 0;
        awaddr <= {idx, 2'h0};
        wdata <= {28'h0000000, d};
        {awvalid, wvalid, bready} <= 3'h7;
        while (!b)
        begin
            // settled values between edges are what the next rising edge samples
            @(negedge ref_clk_i);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            @(posedge ref_clk_i);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            b = tb;
        end
    endtask

    // rready comes up only once data is offered, so the slave must hold it
    task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
        bit          b;
        bit          ta;
        bit          tr;
        bit          rv;
        logic [31:0] rs;
        b = 0;
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        while (!b)
        begin
            @(negedge ref_clk_i);
            ta = arvalid && arready;
            tr = rvalid && rready;
            rv = rvalid;
            rs = rdata;
            @(posedge ref_clk_i);
            if (ta) arvalid <= 1'h0;
            if (tr)
            begin
                rready <= 1'h0;
                rd = rs;
                b = 1;
            end
            else if (rv) rready <= 1'h1;
        end
        check(rd, exp);
    endtask

    task automatic run(input int k);
        stop_mode_i <= 1'h0;
        repeat (k) @(posedge ref_clk_i);
        stop_mode_i <= 1'h1;
    endtask

    task automatic edges(input int k);
        x1_run <= 1'h1;
        repeat (k) @(posedge x1_clk);
        x1_run <= 1'h0;
        repeat (4) @(posedge ref_clk_i);
    endtask

    // pulse is looked at between edges, so a value launched by an edge is never raced
    task automatic waitfor(input logic lvl);
        logic p;
        n = 0;
        do
        begin
            @(negedge ref_clk_i);
            p = pulse;
            @(posedge ref_clk_i);
            n++;
        end
        while (p !== lvl && n < 600);
    endtask

    // load FF, four running cycles give exactly two ticks at the fastest division
    task automatic tmr(input logic [5:0] m, input logic [3:0] mode, input logic [7:0] exp, input logic [31:0] fl);
        wr(m, mode);
        wr(m + 6'h01, 4'hF);
        wr(m + 6'h02, 4'hF);
        run(4);
        rdchk(m + 6'h02, {28'h0000000, exp[7:4]});
        rdchk(m + 6'h01, {28'h0000000, exp[3:0]});
        rdchk(pt_pkg::IDX_FLAG_BC, fl);
        wr(pt_pkg::IDX_FLAG_BC, 4'h0);
    endtask

    initial
    begin
        ref_clk_i = 1'h0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            conclude();
        end
    end

    initial
    begin
        {rst_i, stop_mode_i, watch_mode_i, x1_run, ev_req} = 5'h18;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
        {failures, samples_checked, cycles} = 0;
        rows = '{'{pt_pkg::IDX_PORT_FUNC_SEL_A, 4'hA, 4'hA}, '{pt_pkg::IDX_PORT_FUNC_SEL_B, 4'h4, 4'h4}, '{pt_pkg::IDX_TMA, 4'h7, 4'h0},
                 '{pt_pkg::IDX_TMB, 4'h6, 4'h0}, '{pt_pkg::IDX_TMC, 4'h7, 4'h0}, '{6'h3F, 4'h5, 4'h0}};
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        foreach (rows[i])
        begin
            wr(rows[i].idx, rows[i].wd);
            rdchk(rows[i].idx, {28'h0000000, rows[i].exp});
        end
        check({31'h0, psel}, 32'h1);
        rst_i <= 1'h1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        rdchk(pt_pkg::IDX_PORT_FUNC_SEL_A, 32'h0);
        check({21'h0, sys_prescaler}, 32'h0);
        tmr(pt_pkg::IDX_TMB, 4'h6, 8'h01, 32'h1);
        tmr(pt_pkg::IDX_TMB, 4'hE, 8'hFF, 32'h1);
        tmr(pt_pkg::IDX_TMC, 4'h7, 8'h01, 32'h5);
        tmr(pt_pkg::IDX_TMC, 4'hF, 8'hFF, 32'h5);
        wr(pt_pkg::IDX_TMA, 4'hE);
        wr(pt_pkg::IDX_TMA, 4'h7);
        wr(pt_pkg::IDX_FLAG_A, 4'h0);
        run(510);
        rdchk(pt_pkg::IDX_FLAG_A, 32'h0);
        run(2);
        rdchk(pt_pkg::IDX_FLAG_A, 32'h4);
        // prescaler S is halted here, so only the crystal path can move timer A
        wr(pt_pkg::IDX_TMA, 4'hE);
        wr(pt_pkg::IDX_TMA, 4'hC);
        wr(pt_pkg::IDX_FLAG_A, 4'h0);
        edges(1020);
        rdchk(pt_pkg::IDX_FLAG_A, 32'h0);
        edges(8);
        rdchk(pt_pkg::IDX_FLAG_A, 32'h4);
        wr(pt_pkg::IDX_PORT_FUNC_SEL_A, 4'h8);
        wr(pt_pkg::IDX_TMB, 4'h7);
        wr(pt_pkg::IDX_TCB_LO, 4'hE);
        wr(pt_pkg::IDX_TCB_HI, 4'hF);
        wr(pt_pkg::IDX_FLAG_BC, 4'h0);
        repeat (2)
        begin
            ev_req <= 1'h1;
            @(posedge ref_clk_i);
            ev_req <= 1'h0;
            repeat (5) @(posedge ref_clk_i);
        end
        rdchk(pt_pkg::IDX_TCB_HI, 32'h0);
        rdchk(pt_pkg::IDX_FLAG_BC, 32'h1);
        wr(pt_pkg::IDX_TCC_LO, 4'hF);
        wr(pt_pkg::IDX_TCC_HI, 4'h7);
        stop_mode_i <= 1'h0;
        waitfor(1'h0);
        waitfor(1'h1);
        check(n, 32'd258);
        waitfor(1'h0);
        check(n, 32'h2);
        waitfor(1'h1);
        check(n, 32'd256);
        watch_mode_i <= 1'h1;
        repeat (3) @(posedge ref_clk_i);
        check({31'h0, pulse}, 32'h0);
        {stop_mode_i, watch_mode_i} <= 2'h2;
        wr(pt_pkg::IDX_CTRL, 4'h1);
        rdchk(pt_pkg::IDX_CTRL, 32'h1);
        wr(pt_pkg::IDX_TCC_HI, 4'hF);
        n = 0;
        repeat (30)
        begin
            @(posedge ref_clk_i);
            if (wdt === 1'h1) n++;
        end
        check(n, 32'h0);
        stop_mode_i <= 1'h0;
        n = 0;
        // the request stands one cycle and the reset disarms, so exactly one pulse is seen
        repeat (20)
        begin
            @(negedge ref_clk_i);
            if (wdt === 1'h1) n++;
        end
        @(posedge ref_clk_i);
        check(n, 32'h1);
        stop_mode_i <= 1'h1;
        rdchk(pt_pkg::IDX_CTRL, 32'h0);
        conclude();
    end
endmodule

bind pt_timers pt_timers_assertions chk (.*);
